// ### pcr_ctrl.sv
// performance control register with overflow status and pair selection
// Operation
// - read returns one overflow status bit per counter of every pair
// - writing zero clears an overflow bit unless overflow keep is set
// - writing one into an overflow bit sets it
// - overflow keep guard is write only and reads zero
// - overflow keep holds overflow field for that write; others update
// - overflow status stays current for every later read
// - pair count field read only, encodes pairs minus one
// - pair count field reads three, four pairs present
// - pair select picks visible counter pair and read event selects
// - on write, written pair select picks which pair's selects update
// - event select hold guard is write only and reads zero
// - hold guard set keeps selects; clear loads written selects
// - read always shows current selects of the selected pair
// - upper select at bits 16..11, lower select at bits 9..4
// - bit 0 holds the user access lock
// - unprivileged access with lock one raises privileged action fault
// - unprivileged, lock zero: reads ok; write fault only setting lock
// - counter rollover sets its overflow bit; set bits stay; many at once
// - software set of overflow bits raises no level 15 interrupt
`timescale 1ns/100ps
module pcr_ctrl (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire pcr_pkg::pcr_req_t req_i,
  input  wire logic [7:0]       cnt_wrap_i,
  output pcr_pkg::pcr_rsp_t     rsp_o,
  output logic [2:0]            pair_select_o,
  output logic                  count_user_mode_o,
  output logic                  count_supervisor_mode_o,
  output logic                  ovf_irq_o
);
  import pcr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [7:0] overflow_flags_reg;
  logic [5:0] upper_sel_reg [NUM_PAIRS];
  logic [5:0] lower_sel_reg [NUM_PAIRS];
  logic [2:0] pair_select_reg;
  logic       lock_reg;
  logic       fault;
  logic       wr_ok;
  logic       rd_ok;
  logic [1:0] wsel;

  // ****************************************
  // access check
  // ****************************************
  always_comb begin
    fault = 1'h0;
    if (!req_i.user_access_lock && (req_i.rd || req_i.wr)) begin
      if (lock_reg)
        fault = 1'h1;
      else if (req_i.wr && req_i.wdata[LOCK_BIT])
        fault = 1'h1;
    end
  end

  assign wr_ok = req_i.wr && !fault;
  assign rd_ok = req_i.rd && !fault;
  // only four pairs exist; the top select bit does not address storage
  assign wsel  = req_i.wdata[SEL_LSB +: 2];

  // ****************************************
  // overflow flags
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      overflow_flags_reg <= OVF_RESET;
    end else if (wr_ok && !req_i.wdata[KEEP_OVF_BIT]) begin
      // written value, but a same-cycle rollover still wins
      overflow_flags_reg <= req_i.wdata[OVF_LSB +: OVF_USED]
                            | cnt_wrap_i;
    end else begin
      overflow_flags_reg <= overflow_flags_reg | cnt_wrap_i;
    end
  end

  // interrupt pulse from genuine rollovers only, never from writes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      ovf_irq_o <= 1'h0;
    else
      ovf_irq_o <= |cnt_wrap_i;
  end

  // ****************************************
  // control fields
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pair_select_reg         <= SEL_RESET;
      count_user_mode_o       <= MODE_RESET;
      count_supervisor_mode_o <= MODE_RESET;
      lock_reg                <= LOCK_RESET;
    end else if (wr_ok) begin
      pair_select_reg         <= req_i.wdata[SEL_LSB +: 3];
      count_user_mode_o       <= req_i.wdata[CNT_USER_BIT];
      count_supervisor_mode_o <= req_i.wdata[CNT_SUP_BIT];
      lock_reg                <= req_i.wdata[LOCK_BIT];
    end
  end

  assign pair_select_o = pair_select_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        upper_sel_reg[i] <= EVSEL_RESET;
        lower_sel_reg[i] <= EVSEL_RESET;
      end
    end else if (wr_ok && !req_i.wdata[HOLD_SEL_BIT]) begin
      upper_sel_reg[wsel] <= req_i.wdata[UPPER_LSB +: 6];
      lower_sel_reg[wsel] <= req_i.wdata[LOWER_LSB +: 6];
    end
  end

  // ****************************************
  // read answer
  // ****************************************
  logic [63:0] rd_word;
  always_comb begin
    rd_word = 64'h0;
    rd_word[OVF_LSB +: OVF_USED] = overflow_flags_reg;
    rd_word[NPAIR_LSB +: 3]      = NPAIR_VALUE;
    rd_word[SEL_LSB +: 3]        = pair_select_reg;
    rd_word[UPPER_LSB +: 6]      = upper_sel_reg[pair_select_reg[1:0]];
    rd_word[LOWER_LSB +: 6]      = lower_sel_reg[pair_select_reg[1:0]];
    rd_word[CNT_USER_BIT]        = count_user_mode_o;
    rd_word[CNT_SUP_BIT]         = count_supervisor_mode_o;
    rd_word[LOCK_BIT]            = lock_reg;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.done       <= req_i.rd || req_i.wr;
      rsp_o.user_access_lock_fault <= fault;
      rsp_o.rdata      <= rd_ok ? rd_word : 64'h0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_wrap_sets: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    cnt_wrap_i != 8'h00 |=> (overflow_flags_reg & $past(cnt_wrap_i))
      == $past(cnt_wrap_i))
    else $error("rollover did not set overflow flag");

  a_keep_ovf_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && req_i.wdata[KEEP_OVF_BIT] && cnt_wrap_i == 8'h00
      |=> $stable(overflow_flags_reg))
    else $error("overflow changed under keep guard");

  a_ovf_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && !req_i.wdata[KEEP_OVF_BIT] && cnt_wrap_i == 8'h00
      |=> overflow_flags_reg == $past(req_i.wdata[OVF_LSB +: OVF_USED]))
    else $error("overflow write not applied");

  a_count_field: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rsp_o.done && !rsp_o.user_access_lock_fault && $past(req_i.rd)
      |-> rsp_o.rdata[24:22] == 3'h3)
    else $error("pair count field wrong");

  a_zero_bits: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rsp_o.rdata[63:40] == 24'h0 && rsp_o.rdata[31:25] == 7'h0
      && !rsp_o.rdata[21] && !rsp_o.rdata[17] && !rsp_o.rdata[10]
      && !rsp_o.rdata[3])
    else $error("reserved or guard bit reads nonzero");

  // a faulted access must not leak data or move the lock
  a_locked_fault: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !req_i.user_access_lock && lock_reg && (req_i.rd || req_i.wr)
      |=> rsp_o.user_access_lock_fault && rsp_o.rdata == 64'h0 && $stable(lock_reg))
    else $error("locked user access not faulted");

  a_user_read_ok: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !req_i.user_access_lock && !lock_reg && req_i.rd && !req_i.wr |=> !rsp_o.user_access_lock_fault)
    else $error("unlocked user read faulted");

  a_user_write_chk: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !req_i.user_access_lock && !lock_reg && req_i.wr
      |=> rsp_o.user_access_lock_fault == $past(req_i.wdata[LOCK_BIT]))
    else $error("unlocked user write fault wrong");

  // the written select moves with the next request, so index by its past
  a_hold_sel: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && req_i.wdata[HOLD_SEL_BIT]
      |=> upper_sel_reg[$past(wsel)] == $past(upper_sel_reg[wsel])
      && lower_sel_reg[$past(wsel)] == $past(lower_sel_reg[wsel]))
    else $error("event select changed under hold");

  a_irq_cause: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    ovf_irq_o |-> $past(cnt_wrap_i) != 8'h00)
    else $error("interrupt without rollover");

  c_wrap: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    cnt_wrap_i != 8'h00 ##1 ovf_irq_o);
  c_keep_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && req_i.wdata[KEEP_OVF_BIT]);
  c_hold_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && req_i.wdata[HOLD_SEL_BIT]);
  c_fault: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    rsp_o.user_access_lock_fault);
  c_wrap_vs_clear: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && !req_i.wdata[KEEP_OVF_BIT] && cnt_wrap_i != 8'h00);

endmodule

// ### pcr_pkg.sv
// shared constants and carriers for the performance control register
package pcr_pkg;

  localparam int OVF_LSB      = 32;
  localparam int OVF_W        = 16;
  localparam int OVF_USED     = 8;
  localparam int KEEP_OVF_BIT = 26;
  localparam int NPAIR_LSB    = 22;
  localparam int SEL_LSB      = 18;
  localparam int UPPER_LSB    = 11;
  localparam int LOWER_LSB    = 4;
  localparam int HOLD_SEL_BIT = 3;
  localparam int CNT_USER_BIT = 2;
  localparam int CNT_SUP_BIT  = 1;
  localparam int LOCK_BIT     = 0;
  localparam int NUM_PAIRS    = 4;

  localparam logic [2:0] NPAIR_VALUE  = 3'h3;
  localparam logic [7:0] OVF_RESET    = 8'h00;
  localparam logic [5:0] EVSEL_RESET  = 6'h00;
  localparam logic [2:0] SEL_RESET    = 3'h0;
  localparam logic       MODE_RESET   = 1'b0;
  localparam logic       LOCK_RESET   = 1'b0;

  // one register access from the core pipeline
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        user_access_lock;
    logic [63:0] wdata;
  } pcr_req_t;

  // answer to that access, valid the cycle after the request
  typedef struct packed {
    logic        done;
    logic        user_access_lock_fault;
    logic [63:0] rdata;
  } pcr_rsp_t;

endpackage

// ### test_perf_counter_control_register.sv
// self-checking bench for the performance control register
`timescale 1ns/100ps
module test_perf_counter_control_register;
  import pcr_pkg::*;
  // ********************************************
  // clock, reset and design
  // ********************************************
  logic       clk_sys_i = 1'h0;
  logic       rst_i     = 1'h1;
  pcr_req_t   req       = '0;
  logic [7:0] wrap      = 8'h00;
  pcr_rsp_t   rsp;
  logic [2:0] sel;
  logic       um;
  logic       sm;
  logic       irq;
  int         fail_count = 0;
  int         tests_run  = 0;
  // pair count field always reads three
  localparam logic [63:0] NP = 64'h0000_0000_00C0_0000;

  always #12.5 clk_sys_i = ~clk_sys_i;

  pcr_ctrl pcr_ctrl_inst (
    .clk_sys_i               (clk_sys_i),
    .rst_i                   (rst_i),
    .req_i                   (req),
    .cnt_wrap_i              (wrap),
    .rsp_o                   (rsp),
    .pair_select_o           (sel),
    .count_user_mode_o       (um),
    .count_supervisor_mode_o (sm),
    .ovf_irq_o               (irq)
  );

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access; answer is judged on the falling edge after the taking edge
  task automatic acc(input logic w, input logic p, input logic [63:0] d,
                     input logic f, input logic [63:0] r);
    @(negedge clk_sys_i);
    req <= '{rd: ~w, wr: w, user_access_lock: p, wdata: d};
    @(negedge clk_sys_i);
    req <= '0;
    check("done", {63'h0, rsp.done}, 64'h1);
    check("fault", {63'h0, rsp.user_access_lock_fault}, {63'h0, f});
    check("rdata", rsp.rdata, r);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_reset;
    acc(1'h0, 1'h1, 64'h0, 1'h0, NP);
    $display("test reset done");
  endtask

  // both guards set: overflow and selects must stay, the rest loads
  task automatic t_guards;
    acc(1'h1, 1'h1, 64'hFFFF_FFFF_FFFF_FFFE, 1'h0, 64'h0);
    check("sel", {61'h0, sel}, 64'h7);
    check("modes", {62'h0, um, sm}, 64'h3);
    acc(1'h0, 1'h1, 64'h0, 1'h0, NP | 64'h1C_0006);
    $display("test guards done");
  endtask

  task automatic t_fields;
    acc(1'h1, 1'h1, 64'h0000_00A5_0009_5150, 1'h0, 64'h0);
    check("irq", {63'h0, irq}, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_00A5_00C9_5150);
    acc(1'h1, 1'h1, 64'h0400_0000_0405_FBF8, 1'h0, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_00A5_00C4_0000);
    acc(1'h1, 1'h1, 64'h0000_0000_0408_0008, 1'h0, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_00A5_00C9_5150);
    $display("test fields done");
  endtask

  task automatic t_wrap;
    @(negedge clk_sys_i);
    wrap <= 8'h5A;
    @(negedge clk_sys_i);
    wrap <= 8'h00;
    check("irq", {63'h0, irq}, 64'h1);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_00FF_00C9_5150);
    acc(1'h1, 1'h1, 64'h0000_000F_0009_5150, 1'h0, 64'h0);
    check("irq", {63'h0, irq}, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_000F_00C9_5150);
    // a rollover in the cycle of a clearing write must survive it
    @(negedge clk_sys_i);
    req  <= '{rd: 1'h0, wr: 1'h1, user_access_lock: 1'h1, wdata: 64'h0009_5150};
    wrap <= 8'h30;
    @(negedge clk_sys_i);
    req  <= '0;
    wrap <= 8'h00;
    check("irq", {63'h0, irq}, 64'h1);
    acc(1'h0, 1'h1, 64'h0, 1'h0, 64'h0000_0030_00C9_5150);
    $display("test wrap done");
  endtask

  task automatic t_lock;
    acc(1'h1, 1'h1, 64'h1, 1'h0, 64'h0);
    acc(1'h0, 1'h0, 64'h0, 1'h1, 64'h0);
    acc(1'h1, 1'h0, 64'h0, 1'h1, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, NP | 64'h1);
    acc(1'h1, 1'h1, 64'h0, 1'h0, 64'h0);
    acc(1'h0, 1'h0, 64'h0, 1'h0, NP);
    acc(1'h1, 1'h0, 64'h5, 1'h1, 64'h0);
    acc(1'h1, 1'h0, 64'h4, 1'h0, 64'h0);
    acc(1'h0, 1'h0, 64'h0, 1'h0, NP | 64'h4);
    $display("test lock done");
  endtask

  // reset in mid-run must bring select and modes back to zero
  task automatic t_rerst;
    acc(1'h1, 1'h1, 64'h0014_0006, 1'h0, 64'h0);
    check("sel", {61'h0, sel}, 64'h5);
    @(negedge clk_sys_i);
    rst_i = 1'h1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'h0;
    check("sel", {61'h0, sel}, 64'h0);
    acc(1'h0, 1'h1, 64'h0, 1'h0, NP);
    $display("test mid reset done");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'h0;
    t_reset;
    t_guards;
    t_fields;
    t_wrap;
    t_lock;
    t_rerst;
    report_and_stop;
  end

  // the scenarios need well under a hundred cycles
  initial begin
    #(25 * 1000);
    fail_count++;
    report_and_stop;
  end
endmodule
